/* File: rtl/crr_consts.vh */
`ifndef CRR_CONSTS_VH
`define CRR_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define CRR_IDX_REF_A      8'h9b
`define CRR_IDX_REF_B      8'h9c
`define CRR_IDX_CMP_CTRL   8'h9d
`define CRR_IDX_IRQ_STAT   8'ha0
`define CRR_IDX_IRQ_MASK   8'ha1
`define CRR_IDX_SLEEP_CTRL 8'ha2
`define CRR_IDX_LSB        2

////////////////////////////////////////////////////////////////////////////////
// Comparator control fields, channel n at base 4*n
`define CRR_CC_INVERT      0
`define CRR_CC_PIN_EN      1
`define CRR_CC_RESULT      2
`define CRR_CC_CH_STRIDE   4

// Reference select fields
`define CRR_REF_COARSE_MSB 7
`define CRR_REF_COARSE_LSB 3
`define CRR_REF_FINE_MSB   2
`define CRR_REF_FINE_LSB   0

// Interrupt status / mask layout
`define CRR_IRQ_COMPARE    0
`define CRR_IRQ_A_CHANGE   1
`define CRR_IRQ_B_CHANGE   2
`define CRR_IRQ_W          3

// Sleep control field
`define CRR_SLP_CMP_OFF    2

// Reset values
`define CRR_RST_BYTE       8'h00
`define CRR_RST_IRQ        3'h0
`define CRR_RST_WORD       32'h0000_0000

`endif

/* File: rtl/crr_regs.v */
// The APB slave port was chosen for this implementation.

`include "crr_consts.vh"

module crr_regs #(
  parameter ADDR_W = 10
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              cmp_a_raw,
  input  wire              cmp_b_raw,
  input  wire              global_irq_enable,
  input  wire              peripheral_irq_enable,
  output reg               irq,
  output reg               analog_enable,
  output reg  [4:0]        ref_a_coarse,
  output reg  [2:0]        ref_a_fine,
  output reg  [4:0]        ref_b_coarse,
  output reg  [2:0]        ref_b_fine,
  output reg               port_c_cmp_a_pin_out,
  output reg               port_c_cmp_a_pin_oe,
  output reg               port_c_ref_a_pin_oe,
  output reg               port_d_cmp_b_pin_out,
  output reg               port_d_cmp_b_pin_oe,
  output reg               port_d_ref_b_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  reg  [7:0]         reference_a_select_r;
  reg  [7:0]         reference_b_select_r;
  reg  [1:0]         invert_r;
  reg  [1:0]         pin_en_r;
  reg  [1:0]         sync1_r;
  reg  [1:0]         sync2_r;
  reg  [1:0]         result_r;
  reg  [`CRR_IRQ_W-1:0] irq_stat_r;
  reg  [`CRR_IRQ_W-1:0] irq_mask_r;
  reg                analog_compare_disable_r;
  reg  [`CRR_IRQ_W-1:0] irq_stat_nxt;
  reg  [31:0]        rd_nxt;
  reg                hit;
  wire [1:0]         raw;
  wire [1:0]         result_nxt;
  wire [7:0]         comparator_control;
  wire [7:0]         idx;
  wire               access;
  wire               wr_done;
  wire               wr_ref_a;
  wire               wr_ref_b;
  wire               wr_ctrl;
  wire               wr_stat;
  wire               wr_mask;
  wire               wr_sleep;
  wire               compare_cond;

  assign raw    = {cmp_b_raw, cmp_a_raw};
  assign idx    = paddr[`CRR_IDX_LSB+7:`CRR_IDX_LSB];
  assign access = psel & penable;
  // One wait state: pready rises in the second access cycle
  assign wr_done = access & pready & pwrite;
  // Only the index is decoded: a misaligned write still lands, pslverr flags it
  assign wr_ref_a = wr_done & (idx == `CRR_IDX_REF_A);
  assign wr_ref_b = wr_done & (idx == `CRR_IDX_REF_B);
  assign wr_ctrl  = wr_done & (idx == `CRR_IDX_CMP_CTRL);
  assign wr_stat  = wr_done & (idx == `CRR_IDX_IRQ_STAT);
  assign wr_mask  = wr_done & (idx == `CRR_IDX_IRQ_MASK);
  assign wr_sleep = wr_done & (idx == `CRR_IDX_SLEEP_CTRL);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= access & ~pready;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-comparator path

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_cmp
      // First stage feeds only the second
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_r[ch] <= 1'b0;
          sync2_r[ch] <= 1'b0;
        end
        else
        begin
          sync1_r[ch] <= raw[ch];
          sync2_r[ch] <= sync1_r[ch];
        end
      end

      // Stopped comparators read as low before inversion
      assign result_nxt[ch] = (sync2_r[ch] & ~analog_compare_disable_r)
                              ^ invert_r[ch];

      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          invert_r[ch] <= 1'b0;
          pin_en_r[ch] <= 1'b0;
          result_r[ch] <= 1'b0;
        end
        else
        begin
          result_r[ch] <= result_nxt[ch];
          // Result and unused bits are never stored
          if (wr_ctrl)
          begin
            invert_r[ch] <= pwdata[`CRR_CC_CH_STRIDE*ch+`CRR_CC_INVERT];
            pin_en_r[ch] <= pwdata[`CRR_CC_CH_STRIDE*ch+`CRR_CC_PIN_EN];
          end
        end
      end
    end
  endgenerate

  assign comparator_control = {1'b0, result_r[1], pin_en_r[1], invert_r[1],
                               1'b0, result_r[0], pin_en_r[0], invert_r[0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Writable registers

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reference_a_select_r <= `CRR_RST_BYTE;
    else if (wr_ref_a)
      reference_a_select_r <= pwdata[7:0];
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reference_b_select_r <= `CRR_RST_BYTE;
    else if (wr_ref_b)
      reference_b_select_r <= pwdata[7:0];
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_r <= `CRR_RST_IRQ;
    else if (wr_mask)
      irq_mask_r <= pwdata[`CRR_IRQ_W-1:0];
  end

  // Cleared at reset so references and comparators run from the start
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      analog_compare_disable_r <= 1'b0;
    else if (wr_sleep)
      analog_compare_disable_r <= pwdata[`CRR_SLP_CMP_OFF];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status

  // Level condition: flag re-sets at once while it holds
  assign compare_cond = result_r[0] | result_r[1];

  always @*
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr_stat)
      irq_stat_nxt = irq_stat_r & ~pwdata[`CRR_IRQ_W-1:0];
    // Set after clear so a same-cycle event wins
    if (compare_cond)
      irq_stat_nxt[`CRR_IRQ_COMPARE] = 1'b1;
    if (result_nxt[0] != result_r[0])
      irq_stat_nxt[`CRR_IRQ_A_CHANGE] = 1'b1;
    if (result_nxt[1] != result_r[1])
      irq_stat_nxt[`CRR_IRQ_B_CHANGE] = 1'b1;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_r <= `CRR_RST_IRQ;
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_r & irq_mask_r) & global_irq_enable
             & peripheral_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and pins

  always @*
  begin
    rd_nxt = `CRR_RST_WORD;
    hit    = 1'b1;
    case (idx)
      `CRR_IDX_REF_A:
        rd_nxt[7:0] = reference_a_select_r;
      `CRR_IDX_REF_B:
        rd_nxt[7:0] = reference_b_select_r;
      `CRR_IDX_CMP_CTRL:
        rd_nxt[7:0] = comparator_control;
      `CRR_IDX_IRQ_STAT:
        rd_nxt[`CRR_IRQ_W-1:0] = irq_stat_r;
      `CRR_IDX_IRQ_MASK:
        rd_nxt[`CRR_IRQ_W-1:0] = irq_mask_r;
      `CRR_IDX_SLEEP_CTRL:
        rd_nxt[`CRR_SLP_CMP_OFF] = analog_compare_disable_r;
      default:
        hit = 1'b0;
    endcase
    if (paddr[`CRR_IDX_LSB-1:0] != 2'b00)
      hit = 1'b0;
  end

  // Data and error stand only with pready
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= `CRR_RST_WORD;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= (access && !pready && !pwrite && hit) ? rd_nxt : `CRR_RST_WORD;
      pslverr <= access & ~pready & ~hit;
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_enable <= 1'b0;
      ref_a_coarse  <= 5'h00;
      ref_a_fine    <= 3'h0;
      ref_b_coarse  <= 5'h00;
      ref_b_fine    <= 3'h0;
    end
    else
    begin
      analog_enable <= ~analog_compare_disable_r;
      ref_a_coarse  <= reference_a_select_r[`CRR_REF_COARSE_MSB:`CRR_REF_COARSE_LSB];
      ref_a_fine    <= reference_a_select_r[`CRR_REF_FINE_MSB:`CRR_REF_FINE_LSB];
      ref_b_coarse  <= reference_b_select_r[`CRR_REF_COARSE_MSB:`CRR_REF_COARSE_LSB];
      ref_b_fine    <= reference_b_select_r[`CRR_REF_FINE_MSB:`CRR_REF_FINE_LSB];
    end
  end

  // Pin enables override the port direction setting
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_c_cmp_a_pin_out <= 1'b0;
      port_c_cmp_a_pin_oe  <= 1'b0;
      port_c_ref_a_pin_oe  <= 1'b0;
      port_d_cmp_b_pin_out <= 1'b0;
      port_d_cmp_b_pin_oe  <= 1'b0;
      port_d_ref_b_pin_oe  <= 1'b0;
    end
    else
    begin
      port_c_cmp_a_pin_out <= result_r[0];
      port_c_cmp_a_pin_oe  <= pin_en_r[0];
      port_c_ref_a_pin_oe  <= pin_en_r[0];
      port_d_cmp_b_pin_out <= result_r[1];
      port_d_cmp_b_pin_oe  <= pin_en_r[1];
      port_d_ref_b_pin_oe  <= pin_en_r[1];
    end
  end

endmodule

/* File: sim/crr_regs_chk_props.sv */
`include "crr_consts.vh"
module crr_regs_chk #(parameter ADDR_W = 10) (
  input logic              clock, rst_n, psel, penable, pwrite, pready, pslverr,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0]       pwdata, prdata,
  input logic              cmp_a_raw, global_irq_enable, peripheral_irq_enable, irq,
  input logic              analog_enable, port_c_cmp_a_pin_out,
  input logic [4:0]        ref_a_coarse, ref_b_coarse,
  input logic [2:0]        ref_a_fine, ref_b_fine,
  input logic              port_c_cmp_a_pin_oe, port_c_ref_a_pin_oe,
  input logic              port_d_cmp_b_pin_oe, port_d_ref_b_pin_oe
);
  localparam [9:0] RA = {`CRR_IDX_REF_A, 2'b00};
  localparam [9:0] RB = {`CRR_IDX_REF_B, 2'b00};
  localparam [9:0] CC = {`CRR_IDX_CMP_CTRL, 2'b00};
  localparam [9:0] SL = {`CRR_IDX_SLEEP_CTRL, 2'b00};
  wire wr = psel & penable & pready & pwrite;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  chk_one_wait: assert property (psel && !penable |=> !pready) else $error("no wait state");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  // Register then output flop: the pins follow a write two edges later
  chk_ref_a_load: assert property (wr && paddr == RA |=> ##1
    {ref_a_coarse, ref_a_fine} == $past(pwdata[7:0], 2)) else $error("ref a select");
  chk_ref_b_load: assert property (wr && paddr == RB |=> ##1
    {ref_b_coarse, ref_b_fine} == $past(pwdata[7:0], 2)) else $error("ref b select");
  chk_pin_en_load: assert property (wr && paddr == CC |=> ##1
    port_c_cmp_a_pin_oe == $past(pwdata[1], 2) && port_d_cmp_b_pin_oe == $past(pwdata[5], 2))
    else $error("pin enable");
  chk_ref_pin_pair: assert property (port_c_ref_a_pin_oe == port_c_cmp_a_pin_oe &&
    port_d_ref_b_pin_oe == port_d_cmp_b_pin_oe) else $error("pin pair");
  chk_unused_zero: assert property (pready && !pwrite && paddr == CC |->
    prdata[7] == 1'b0 && prdata[3] == 1'b0) else $error("unused bits");
  chk_irq_gate: assert property (!global_irq_enable || !peripheral_irq_enable |=> !irq)
    else $error("irq not gated");
  chk_sleep_load: assert property (wr && paddr == SL |=> ##1
    analog_enable == !$past(pwdata[2], 2)) else $error("analog enable");
  // Raw input passes four flops (two sync, result, pin) before reaching the pin
  chk_sync_delay: assert property ($changed(cmp_a_raw) && !wr |=>
    $stable(port_c_cmp_a_pin_out)[*3]) else $error("sync bypassed");
  cover property (wr && paddr == RA);
  cover property (irq);
  cover property (pready && pslverr);
endmodule

/* File: sim/crr_regs_test.sv */
`include "crr_consts.vh"
module crr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [9:0] RA = {`CRR_IDX_REF_A, 2'b00};
  localparam [9:0] RB = {`CRR_IDX_REF_B, 2'b00};
  localparam [9:0] CC = {`CRR_IDX_CMP_CTRL, 2'b00};
  localparam [9:0] ST = {`CRR_IDX_IRQ_STAT, 2'b00};
  localparam [9:0] MK = {`CRR_IDX_IRQ_MASK, 2'b00};
  localparam [9:0] SL = {`CRR_IDX_SLEEP_CTRL, 2'b00};
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic cmp_a_raw = 0, cmp_b_raw = 0, global_irq_enable = 0, peripheral_irq_enable = 0;
  logic [9:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire  [31:0] prdata;
  wire  pready, pslverr, irq, analog_enable;
  wire  [4:0]  ref_a_coarse, ref_b_coarse;
  wire  [2:0]  ref_a_fine, ref_b_fine;
  wire  port_c_cmp_a_pin_out, port_c_cmp_a_pin_oe, port_c_ref_a_pin_oe;
  wire  port_d_cmp_b_pin_out, port_d_cmp_b_pin_oe, port_d_ref_b_pin_oe;
  int   miscompares = 0, n_checks = 0;
  crr_regs dut_u (.*);
  initial forever #5 clock = ~clock;
  ////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    // No cycle limit here: only the watchdog ends a wait
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [9:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
    chk(er, 0);
  endtask
  // Comparator path is 4 edges deep; 6 leaves margin
  task settle;
    repeat (6) @(negedge clock);
  endtask
  task raw_a(input logic v);
    @(posedge clock);
    cmp_a_raw <= v;
    settle;
  endtask
  ////////////////////////////////////////
  task t_reset;
    rdchk(RA, 0);
    rdchk(RB, 0);
    rdchk(CC, 0);
    $display("reset values done");
  endtask
  task t_refs;
    apb(1, RA, 32'h0000_00a5);
    apb(1, RB, 32'h0000_005a);
    repeat (2) @(negedge clock);
    chk({ref_a_coarse, ref_a_fine, ref_b_coarse, ref_b_fine}, 32'ha55a);
    rdchk(RA, 32'ha5);
    rdchk(RB, 32'h5a);
    $display("reference select done");
  endtask
  task t_ctrl;
    apb(1, CC, 32'hff);
    settle;
    rdchk(CC, 32'h77);
    chk({port_c_cmp_a_pin_out, port_c_cmp_a_pin_oe, port_c_ref_a_pin_oe, port_d_cmp_b_pin_out,
      port_d_cmp_b_pin_oe, port_d_ref_b_pin_oe}, 32'h3f);
    raw_a(1);
    apb(1, CC, 32'hee);
    settle;
    rdchk(CC, 32'h26);
    chk({port_c_cmp_a_pin_out, port_d_cmp_b_pin_out}, 32'h2);
    @(posedge clock);
    cmp_b_raw <= 1;
    settle;
    rdchk(CC, 32'h66);
    chk(port_d_cmp_b_pin_out, 1);
    @(posedge clock);
    cmp_b_raw <= 0;
    settle;
    apb(1, CC, 0);
    repeat (2) @(negedge clock);
    chk({port_c_cmp_a_pin_oe, port_c_ref_a_pin_oe, port_d_cmp_b_pin_oe,
      port_d_ref_b_pin_oe}, 0);
    $display("comparator control done");
  endtask
  task t_irq;
    apb(1, ST, 32'h7);
    settle;
    rdchk(ST, 32'h1);
    global_irq_enable <= 1;
    peripheral_irq_enable <= 1;
    apb(1, MK, 32'h1);
    settle;
    chk(irq, 1);
    @(posedge clock);
    peripheral_irq_enable <= 0;
    settle;
    chk(irq, 0);
    @(posedge clock);
    peripheral_irq_enable <= 1;
    apb(1, MK, 0);
    settle;
    chk(irq, 0);
    raw_a(0);
    apb(1, ST, 32'h7);
    rdchk(ST, 0);
    $display("interrupt done");
  endtask
  task t_sleep;
    apb(1, SL, 32'h4);
    repeat (2) @(negedge clock);
    chk(analog_enable, 0);
    raw_a(1);
    rdchk(CC, 0);
    apb(1, SL, 0);
    repeat (2) @(negedge clock);
    chk(analog_enable, 1);
    raw_a(0);
    $display("sleep control done");
  endtask
  task t_bad;
    apb(0, 10'h3fc, 0);
    chk(rd, 0);
    chk(er, 1);
    apb(1, RA | 10'h1, 32'hff);
    chk(er, 1);
    // Only the index is decoded, so the misaligned write still lands
    rdchk(RA, 32'hff);
    $display("refused access done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1;
    t_reset;
    t_refs;
    t_ctrl;
    t_irq;
    t_sleep;
    t_bad;
    report_and_stop;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    #50us;
    miscompares++;
    report_and_stop;
  end
endmodule
bind crr_regs crr_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
